// ==== hdl/fsp_cfg.svh ====
// fsp_cfg.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the flash self-program control files
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// register byte offsets
`define FSP_ADDR_CTRL      8'h00
`define FSP_ADDR_LOCK      8'h04
// control field positions
`define FSP_BIT_IE         7
`define FSP_BIT_BUSY       6
`define FSP_BIT_REEN       4
// low five control bit patterns
`define FSP_PAT_LOAD       5'h01
`define FSP_PAT_ERASE      5'h03
`define FSP_PAT_WRITE      5'h05
`define FSP_PAT_LOCK       5'h09
`define FSP_PAT_REEN       5'h11
// reset values
`define FSP_CTRL_RST       5'h00
`define FSP_LOCK_RST       8'hFF
`define FSP_ERASED         16'hFFFF
// first page of the section that cannot be read while written
`define FSP_NO_CONCURRENT_READ_AREA_FIRST     9'h1C0
// timing
`define FSP_CLK_NS         20
`define FSP_T_OP_MIN_NS    3700000
`define FSP_T_OP_MAX_NS    4500000
`define FSP_OP_MIN_CYC     ((`FSP_T_OP_MIN_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_ARM_LAST       3'h3
// axi responses
`define FSP_RESP_OKAY      2'h0
`define FSP_RESP_SLVERR    2'h2

`endif

// ==== hdl/fsp_pkg.sv ====
// fsp_pkg.sv: types of the flash self-program control block
// assumes nothing beyond a SystemVerilog compiler
package fsp_pkg;
    typedef logic [7:0]  fsp_addr_t;
    typedef logic [15:0] fsp_word_t;
    typedef logic [8:0]  fsp_page_t;
    typedef logic [5:0]  fsp_widx_t;

    typedef enum logic [2:0] {
        FSP_IDLE  = 3'b001,
        FSP_ARMED = 3'b010,
        FSP_OP    = 3'b100
    } fsp_state_e;

    typedef enum logic [1:0] {
        FSP_OP_ERASE = 2'h0,
        FSP_OP_WRITE = 2'h1,
        FSP_OP_LOCK  = 2'h2
    } fsp_op_e;
endpackage : fsp_pkg

// ==== hdl/fsp_ctrl.sv ====
// fsp_ctrl.sv: flash self-program control with axi4-lite control register
// assumes core-side strobes come from logic on aclk; flash macro reads the
// page buffer through the buffer read port while a page write runs
//
// Our own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "fsp_cfg.svh"

// Function
// - armed page write runs on next store
// - erase and write use pointer page bits
// - page write bit clears on done or timeout
// - halt cpu for no concurrent read area
// - armed page erase runs on next store
// - page erase bit clears on done or timeout
// - store acts only within four cycles after arming
// - plain store loads data pair into buffer
// - store enable clears, held during operation
// - undefined low five bit patterns ignored
// - target page latched at operation start
// - lock bit setting ignores the pointer
// - program load uses pointer bit zero
// - buffer words written in any order
// - buffer clears on write, reenable, reset
// - eeprom write discards loaded buffer data
// - irq level while store enable is clear
// - busy set, reads blocked for concurrent area
// - reenable store clears busy and restores reads
// - erase or write lasts the timed duration
module fsp_ctrl #(
    parameter int OP_CYCLES = `FSP_OP_MIN_CYC
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire fsp_pkg::fsp_addr_t s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire fsp_pkg::fsp_addr_t s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              store_instr,
    input  wire fsp_pkg::fsp_word_t store_ptr,
    input  wire fsp_pkg::fsp_word_t store_data,
    input  wire logic              load_program_instr,
    input  wire fsp_pkg::fsp_word_t load_ptr,
    input  wire logic              eeprom_write,
    input  wire fsp_pkg::fsp_widx_t flash_buf_idx,
    output fsp_pkg::fsp_word_t     flash_buf_word,
    output logic                   flash_start,
    output logic                   flash_is_erase,
    output fsp_pkg::fsp_page_t     flash_page,
    output logic                   cpu_halt,
    output logic                   store_ready_irq,
    output logic [14:0]            rd_word_addr,
    output logic                   rd_byte_sel,
    output logic                   rd_valid,
    output logic                   rd_blocked
);
    import fsp_pkg::*;

    localparam logic [17:0] OP_LAST = 18'(OP_CYCLES - 1);

    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    fsp_state_e  state_reg;
    fsp_op_e     op_kind_reg;
    logic [4:0]  cmd_reg;
    logic        irq_enable_reg;
    logic        section_busy_reg;
    logic [2:0]  win_cnt_reg;
    logic [17:0] op_cnt_reg;
    fsp_page_t   op_page_reg;
    logic [3:0]  lock_data_reg;
    logic [7:0]  lock_bits_reg;
    fsp_word_t   buf_mem [64];
    logic        aw_hold_reg;
    logic        w_hold_reg;
    fsp_addr_t   aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;

    function automatic logic in_no_concurrent_read_area(input fsp_word_t ptr);
        in_no_concurrent_read_area = (ptr[15:7] >= `FSP_NO_CONCURRENT_READ_AREA_FIRST);
    endfunction : in_no_concurrent_read_area

    function automatic logic pat_ok(input logic [4:0] pat);
        pat_ok = (pat == `FSP_PAT_LOAD) || (pat == `FSP_PAT_ERASE)
            || (pat == `FSP_PAT_WRITE) || (pat == `FSP_PAT_LOCK)
            || (pat == `FSP_PAT_REEN);
    endfunction : pat_ok

    logic ctl_wr_go;
    logic cmd_take;
    logic store_go;
    logic op_done;
    logic buf_clear;
    logic [4:0] new_pat;

    assign new_pat   = w_data_reg[4:0];
    assign ctl_wr_go = aw_hold_reg && w_hold_reg && !s_axi_bvalid
        && (aw_addr_reg == `FSP_ADDR_CTRL) && w_strb_reg[0];
    assign cmd_take  = ctl_wr_go && (state_reg != FSP_OP) && pat_ok(new_pat);
    assign store_go  = store_instr && (state_reg == FSP_ARMED) && !ctl_wr_go;
    assign op_done   = (state_reg == FSP_OP) && (op_cnt_reg == OP_LAST);
    assign buf_clear = (op_done && op_kind_reg == FSP_OP_WRITE)
        || (cmd_take && new_pat[`FSP_BIT_REEN])
        || eeprom_write;

    // --------------------------------------------------------------
    // axi4-lite write channel
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= 8'h00;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `FSP_RESP_OKAY;
        end
        else if (ce)
        begin
            s_axi_awready <= !aw_hold_reg && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_hold_reg && !(s_axi_wvalid && s_axi_wready);
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_hold_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_hold_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
            if (aw_hold_reg && w_hold_reg && !s_axi_bvalid)
            begin
                aw_hold_reg  <= 1'b0;
                w_hold_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (aw_addr_reg == `FSP_ADDR_CTRL
                    || aw_addr_reg == `FSP_ADDR_LOCK) ? `FSP_RESP_OKAY : `FSP_RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // axi4-lite read channel
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `FSP_RESP_OKAY;
        end
        else if (ce)
        begin
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid  <= 1'b1;
                s_axi_rresp   <= `FSP_RESP_OKAY;
                s_axi_rdata   <= 32'h0000_0000;
                if (s_axi_araddr == `FSP_ADDR_CTRL)
                    s_axi_rdata[7:0] <= {irq_enable_reg, section_busy_reg, 1'b0, cmd_reg};
                else if (s_axi_araddr == `FSP_ADDR_LOCK)
                    s_axi_rdata[7:0] <= lock_bits_reg;
                else
                    s_axi_rresp <= `FSP_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
            else if (!s_axi_rvalid)
            begin
                s_axi_arready <= 1'b1;
            end
        end
    end

    // --------------------------------------------------------------
    // command sequencer
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg      <= FSP_IDLE;
            cmd_reg        <= `FSP_CTRL_RST;
            irq_enable_reg <= 1'b0;
            win_cnt_reg    <= 3'h0;
        end
        else if (ce)
        begin
            if (ctl_wr_go)
                irq_enable_reg <= w_data_reg[`FSP_BIT_IE];
            unique case (state_reg)
                FSP_IDLE, FSP_ARMED:
                begin
                    if (cmd_take)
                    begin
                        cmd_reg     <= new_pat;
                        state_reg   <= FSP_ARMED;
                        win_cnt_reg <= 3'h0;
                    end
                    else if (store_go)
                    begin
                        if (cmd_reg == `FSP_PAT_ERASE || cmd_reg == `FSP_PAT_WRITE
                            || cmd_reg == `FSP_PAT_LOCK)
                            state_reg <= FSP_OP;
                        else
                        begin
                            state_reg <= FSP_IDLE;
                            cmd_reg   <= `FSP_CTRL_RST;
                        end
                    end
                    else if (state_reg == FSP_ARMED)
                    begin
                        if (win_cnt_reg == `FSP_ARM_LAST)
                        begin
                            state_reg <= FSP_IDLE;
                            cmd_reg   <= `FSP_CTRL_RST;
                        end
                        else
                            win_cnt_reg <= win_cnt_reg + 3'h1;
                    end
                end
                FSP_OP:
                begin
                    if (op_done)
                    begin
                        state_reg <= FSP_IDLE;
                        cmd_reg   <= `FSP_CTRL_RST;
                    end
                end
                default:
                begin
                    state_reg <= FSP_IDLE;
                    cmd_reg   <= `FSP_CTRL_RST;
                end
            endcase
        end
    end

    // --------------------------------------------------------------
    // programming operation
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            op_kind_reg      <= FSP_OP_ERASE;
            op_cnt_reg       <= 18'h0_0000;
            op_page_reg      <= 9'h000;
            lock_data_reg    <= 4'hF;
            lock_bits_reg    <= `FSP_LOCK_RST;
            section_busy_reg <= 1'b0;
            cpu_halt         <= 1'b0;
            flash_start      <= 1'b0;
            flash_is_erase   <= 1'b0;
            flash_page       <= 9'h000;
        end
        else if (ce)
        begin
            flash_start <= 1'b0;
            if (store_go && (cmd_reg == `FSP_PAT_ERASE || cmd_reg == `FSP_PAT_WRITE))
            begin
                op_kind_reg    <= (cmd_reg == `FSP_PAT_ERASE) ? FSP_OP_ERASE : FSP_OP_WRITE;
                op_cnt_reg     <= 18'h0_0000;
                op_page_reg    <= store_ptr[15:7];
                flash_page     <= store_ptr[15:7];
                flash_is_erase <= (cmd_reg == `FSP_PAT_ERASE);
                flash_start    <= 1'b1;
                if (in_no_concurrent_read_area(store_ptr))
                    cpu_halt <= 1'b1;
                else
                    section_busy_reg <= 1'b1;
            end
            else if (store_go && cmd_reg == `FSP_PAT_LOCK)
            begin
                op_kind_reg   <= FSP_OP_LOCK;
                op_cnt_reg    <= 18'h0_0000;
                lock_data_reg <= store_data[5:2];
            end
            else if (store_go && (cmd_reg == `FSP_PAT_REEN || cmd_reg == `FSP_PAT_LOAD))
                section_busy_reg <= 1'b0;
            else if (state_reg == FSP_OP)
            begin
                if (op_done)
                begin
                    cpu_halt <= 1'b0;
                    if (op_kind_reg == FSP_OP_LOCK)
                        lock_bits_reg[5:2] <= lock_bits_reg[5:2] & lock_data_reg;
                end
                else
                    op_cnt_reg <= op_cnt_reg + 18'h0_0001;
            end
        end
    end

    // --------------------------------------------------------------
    // temporary page buffer
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn || (ce && buf_clear))
        begin
            for (int i = 0; i < 64; i++)
                buf_mem[i] <= `FSP_ERASED;
        end
        else if (ce && store_go && cmd_reg == `FSP_PAT_LOAD)
            buf_mem[store_ptr[6:1]] <= store_data;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            flash_buf_word <= `FSP_ERASED;
        else if (ce)
            flash_buf_word <= buf_mem[flash_buf_idx];
    end

    // --------------------------------------------------------------
    // program load path and ready interrupt
    // --------------------------------------------------------------
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_word_addr    <= 15'h0000;
            rd_byte_sel     <= 1'b0;
            rd_valid        <= 1'b0;
            rd_blocked      <= 1'b0;
            store_ready_irq <= 1'b0;
        end
        else if (ce)
        begin
            rd_valid        <= load_program_instr;
            rd_blocked      <= load_program_instr && section_busy_reg
                && !in_no_concurrent_read_area(load_ptr);
            if (load_program_instr)
            begin
                rd_word_addr <= load_ptr[15:1];
                rd_byte_sel  <= load_ptr[0];
            end
            store_ready_irq <= irq_enable_reg && !cmd_reg[0];
        end
    end

    // --------------------------------------------------------------
    // assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn || !ce);

    a_arm_timeout: assert property (
        state_reg == FSP_ARMED && win_cnt_reg == `FSP_ARM_LAST && !store_instr && !ctl_wr_go
        |=> state_reg == FSP_IDLE && cmd_reg == `FSP_CTRL_RST)
        else $error("armed command did not time out");
    a_bad_pattern: assert property (
        ctl_wr_go && !pat_ok(new_pat) && state_reg == FSP_IDLE |=> $stable(cmd_reg))
        else $error("undefined pattern changed command");
    a_page_latched: assert property (
        state_reg == FSP_OP && !op_done |=> $stable(op_page_reg) && $stable(flash_page))
        else $error("target page moved during operation");
    a_no_concurrent_read_area_halt: assert property (
        store_go && (cmd_reg == `FSP_PAT_ERASE || cmd_reg == `FSP_PAT_WRITE)
        && in_no_concurrent_read_area(store_ptr) |=> cpu_halt && flash_start && state_reg == FSP_OP)
        else $error("cpu not halted for protected page");
    a_enable_held: assert property (
        state_reg == FSP_OP |-> cmd_reg[0])
        else $error("store enable dropped during operation");
    a_irq_level: assert property (
        ##1 store_ready_irq == $past(irq_enable_reg && !cmd_reg[0]))
        else $error("ready interrupt level wrong");
    a_busy_set: assert property (
        store_go && (cmd_reg == `FSP_PAT_ERASE || cmd_reg == `FSP_PAT_WRITE)
        && !in_no_concurrent_read_area(store_ptr) |=> section_busy_reg [*2])
        else $error("section busy not set");
    a_reen_clear: assert property (
        store_go && cmd_reg == `FSP_PAT_REEN |=> !section_busy_reg)
        else $error("reenable did not clear busy");
    a_op_length: assert property (
        state_reg == FSP_OP && op_cnt_reg < OP_LAST |=> state_reg == FSP_OP)
        else $error("operation ended early");
    a_buf_wipe: assert property (
        eeprom_write |=> buf_mem[0] == `FSP_ERASED && buf_mem[63] == `FSP_ERASED)
        else $error("buffer not discarded");
    a_byte_sel: assert property (
        load_program_instr && load_ptr[0] |=> rd_byte_sel && rd_valid)
        else $error("byte select lost");
    a_unarmed_store: assert property (
        state_reg == FSP_IDLE && store_instr && !ctl_wr_go
        |=> state_reg == FSP_IDLE && $stable(lock_bits_reg) && !flash_start)
        else $error("unarmed store acted");

    c_erase: cover property (store_go && cmd_reg == `FSP_PAT_ERASE);
    c_write: cover property (op_done && op_kind_reg == FSP_OP_WRITE);
    c_load: cover property (store_go && cmd_reg == `FSP_PAT_LOAD);
    c_timeout: cover property (state_reg == FSP_ARMED && win_cnt_reg == `FSP_ARM_LAST);
endmodule : fsp_ctrl

// ==== sim/fsp_core_model.sv ====
// fsp_core_model.sv: core side issuing store, program-load and eeprom pulses
// assumes aclk from the bench; each task starts and ends on a rising edge
`timescale 1ns/1ps
module fsp_core_model (
    input  wire logic          aclk,
    output logic               store_instr,
    output fsp_pkg::fsp_word_t store_ptr,
    output fsp_pkg::fsp_word_t store_data,
    output logic               load_program_instr,
    output fsp_pkg::fsp_word_t load_ptr,
    output logic               eeprom_write
);
    import fsp_pkg::*;
    initial
    begin
        {store_instr, load_program_instr, eeprom_write} = 3'h0;
        {store_ptr, store_data, load_ptr} = '0;
    end
    // store after dly spare edges; lines turn to inverse once released
    task automatic store(input fsp_word_t p, input fsp_word_t d, input int dly);
        repeat (1 + dly) @(posedge aclk);
        store_instr <= 1'b1;
        store_ptr   <= p;
        store_data  <= d;
        @(posedge aclk);
        store_instr <= 1'b0;
        store_ptr   <= ~p;
        store_data  <= ~d;
    endtask : store
    task automatic load(input fsp_word_t p);
        @(posedge aclk);
        load_program_instr <= 1'b1;
        load_ptr           <= p;
        @(posedge aclk);
        load_program_instr <= 1'b0;
        load_ptr           <= ~p;
        @(posedge aclk);
    endtask : load
    task automatic eeprom();
        @(posedge aclk);
        eeprom_write <= 1'b1;
        @(posedge aclk);
        eeprom_write <= 1'b0;
    endtask : eeprom
endmodule : fsp_core_model

// ==== sim/flash_self_program_control_tb_top.sv ====
// flash_self_program_control_tb_top.sv: self-checking bench of fsp_ctrl
// assumes fsp_pkg, fsp_cfg.svh and the core model are compiled first
`timescale 1ns/1ps
module flash_self_program_control_tb_top;
    import fsp_pkg::*;
    localparam int OPC = 20;
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, store_instr, load_program_instr, eeprom_write, flash_start;
    logic flash_is_erase, cpu_halt, store_ready_irq, rd_byte_sel, rd_valid, rd_blocked;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    logic [14:0] rd_word_addr;
    fsp_addr_t   s_axi_awaddr, s_axi_araddr;
    fsp_word_t   store_ptr, store_data, load_ptr, flash_buf_word, w [4];
    fsp_widx_t   flash_buf_idx, ix [4];
    fsp_page_t   flash_page, pg;
    int          fail_count = 0, checked = 0, cyc = 0, starts = 0;
    fsp_ctrl #(.OP_CYCLES(OPC)) i_fsp_ctrl (.aclk, .aresetn, .ce, .s_axi_awvalid,
        .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
        .s_axi_rresp, .store_instr, .store_ptr, .store_data, .load_program_instr,
        .load_ptr, .eeprom_write, .flash_buf_idx, .flash_buf_word, .flash_start,
        .flash_is_erase, .flash_page, .cpu_halt, .store_ready_irq, .rd_word_addr,
        .rd_byte_sel, .rd_valid, .rd_blocked);
    fsp_core_model i_fsp_core_model (.aclk, .store_instr, .store_ptr, .store_data,
        .load_program_instr, .load_ptr, .eeprom_write);
    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    task automatic tally_and_finish();
        if (fail_count == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1)
        begin
            fail_count++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask : chk
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (flash_start === 1'b1)
            starts <= starts + 1;
        if (cyc == 5000)
        begin
            chk(1'b0, "timeout");
            tally_and_finish();
        end
    end
    task automatic axw(input fsp_addr_t a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_bready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1)
                s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : axw
    task automatic axr(input fsp_addr_t a);
        @(posedge aclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1)
                s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : axr
    task automatic bufchk(input fsp_widx_t i, input fsp_word_t e);
        @(posedge aclk);
        flash_buf_idx <= i;
        repeat (2) @(posedge aclk);
        chk(flash_buf_word === e, "buffer word");
    endtask : bufchk
    task automatic ld(input fsp_word_t p, input logic blk);
        i_fsp_core_model.load(p);
        chk(rd_valid === 1'b1 && rd_word_addr === p[15:1] && rd_byte_sel === p[0], "load");
        chk(rd_blocked === blk, "blocked");
    endtask : ld
    function automatic logic no_concurrent_read_area(input fsp_page_t p);
        return p >= 9'h1c0;
    endfunction : no_concurrent_read_area
    task automatic op(input logic [4:0] c, input fsp_page_t p);
        int n;
        n = starts;
        axw(8'h00, {27'h0, c});
        i_fsp_core_model.store({p, 7'h00}, 16'($urandom), 0);
        axr(8'h00);
        chk(rd[2:0] === c[2:0] && rd[6] === !no_concurrent_read_area(p), "op status");
        chk(starts === n + 1 && flash_page === p, "op start");
        chk(flash_is_erase === (c == 5'h03) && cpu_halt === no_concurrent_read_area(p), "op kind");
        repeat (OPC - 6) @(posedge aclk);
        chk(cpu_halt === no_concurrent_read_area(p), "halt span");
        repeat (5) @(posedge aclk);
        chk(cpu_halt === 1'b0 && flash_page === p, "op end");
        axr(8'h00);
        chk(rd[4:0] === 5'h00, "op clear");
    endtask : op
    initial
    begin
        {ce, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'b10000;
        {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
        {s_axi_wdata, flash_buf_idx} = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'hcf43_b71c));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        axr(8'h00);
        chk(rd === 32'h0000_0000, "ctrl reset");
        axw(8'h04, 32'h0000_0000);
        axr(8'h04);
        chk(rd === 32'h0000_00ff, "lock read only");
        axr(8'h08);
        chk(rsp === 2'h2, "unmapped");
        axw(8'h00, 32'h0000_0007);
        axr(8'h00);
        chk(rd[4:0] === 5'h00, "bad pattern");
        for (int k = 1; k < 6; k += 2)
        begin
            axw(8'h00, 32'(k));
            repeat (6) @(posedge aclk);
            axr(8'h00);
            chk(rd[4:0] === 5'h00, "window timeout");
        end
        for (int k = 0; k < 4; k++)
        begin
            ix[k] = 6'((3 - k) * 13 + $urandom_range(0, 12));
            w[k] = 16'($urandom);
            axw(8'h00, 32'h0000_0001);
            i_fsp_core_model.store({9'h0, ix[k], 1'b1}, w[k], k % 2);
        end
        foreach (ix[k])
            bufchk(ix[k], w[k]);
        i_fsp_core_model.store({9'h0, ix[0], 1'b0}, ~w[0], 0);
        bufchk(ix[0], w[0]);
        axw(8'h00, 32'h0000_0001);
        i_fsp_core_model.store({9'h0, ix[1], 1'b0}, ~w[1], 3);
        bufchk(ix[1], w[1]);
        op(5'h03, 9'h1c0 + 9'($urandom_range(0, 63)));
        pg = 9'($urandom_range(0, 447));
        op(5'h03, pg);
        op(5'h05, pg);
        ld({pg, 7'($urandom)}, 1'b1);
        bufchk(ix[0], 16'hffff);
        axw(8'h00, 32'h0000_0011);
        i_fsp_core_model.store(16'h0000, 16'h0000, 0);
        axr(8'h00);
        chk(rd[6] === 1'b0, "busy cleared");
        ld({pg, 7'($urandom)}, 1'b0);
        axw(8'h00, 32'h0000_0001);
        i_fsp_core_model.store({9'h0, ix[2], 1'b0}, w[2], 0);
        i_fsp_core_model.eeprom();
        bufchk(ix[2], 16'hffff);
        axw(8'h00, 32'h0000_0009);
        i_fsp_core_model.store(16'($urandom), 16'h0028, 0);
        repeat (OPC + 4) @(posedge aclk);
        axr(8'h04);
        chk(rd === 32'h0000_00eb, "lock bits set");
        axw(8'h00, 32'h0000_0080);
        repeat (2) @(posedge aclk);
        chk(store_ready_irq === 1'b1, "irq on");
        axw(8'h00, 32'h0000_0081);
        @(posedge aclk);
        chk(store_ready_irq === 1'b0, "irq off");
        tally_and_finish();
    end
endmodule : flash_self_program_control_tb_top
